// ===== rtl/ddr_dev.sv
// memory device end: command decode, bank array, burst data, termination
`timescale 1ns/1ps
module ddr_dev import ddr_pkg::*; (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic cfg_x16,
	ddr_link.dev      lnk,
	output logic      in_sref,
	output logic      x16_mode,
	output logic      err_undef
);
	typedef enum logic [4:0] {
		D_IDLE  = 5'h01,
		D_WR    = 5'h02,
		D_RWAIT = 5'h04,
		D_RD    = 5'h08,
		D_SREF  = 5'h10
	} dst_e;

	dst_e              st_r;         // device state
	dst_e              st_nxt;       // next state
	logic [1:0]        beat_r;       // clock within a burst
	logic [1:0]        beat_nxt;     // next burst clock
	logic [IDX_W-1:0]  idx_r;        // latched array index
	logic [IDX_W-1:0]  idx_cmd;      // index on the command pins
	logic [IDX_W-1:0]  rd_idx;       // index used for read data
	logic [WORD_W-1:0] mem [MEM_DEPTH]; // bank array
	logic [WORD_W-1:0] rword;        // word being read
	logic [WORD_W-1:0] wbuf_r;       // write word being assembled
	logic [WORD_W-1:0] wfull;        // write word with current clock
	logic [N_BYTES-1:0] wen_r;       // byte enables assembled
	logic [N_BYTES-1:0] wfull_en;    // byte enables with current clock
	logic [DQ_W-1:0]   dq_nxt;       // next read drive
	logic [1:0]        dm_nxt;       // next inversion flags
	logic              dbi_on;       // inversion mode selected
	logic              strap_done_r; // strap already caught
	logic              sr_exit_r;    // first clock after self refresh
	logic              cmd_bad;      // command outside the defined set
	logic [8:0]        enc;          // coded byte scratch

	assign dbi_on  = (lnk.mr_dm == DMF_DBI);
	assign idx_cmd = {bank_idx(lnk.bg, lnk.ba, x16_mode), lnk.col};
	assign rd_idx  = (st_r == D_IDLE) ? idx_cmd : idx_r;
	assign rword   = mem[rd_idx];

	// bank count strap caught once after reset release
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			x16_mode     <= RST_LOW;
			strap_done_r <= RST_LOW;
		end else if (!strap_done_r) begin
			x16_mode     <= cfg_x16;
			strap_done_r <= 1'b1;
		end
	end

	// next state: bursts take four clocks, reads wait one more with dll off
	always_comb begin
		st_nxt   = st_r;
		beat_nxt = beat_r;
		case (st_r)
			D_IDLE: begin
				if (!lnk.cs_n && lnk.cke && lnk.cmd == CMD_WR) begin
					st_nxt   = D_WR;
					beat_nxt = 2'h0;
				end else if (!lnk.cs_n && lnk.cke && lnk.cmd == CMD_RD) begin
					st_nxt   = lnk.mr_dll_off ? D_RWAIT : D_RD;
					beat_nxt = 2'h0;
				end else if (!lnk.cs_n && !lnk.cke && lnk.cmd == CMD_SRE) begin
					st_nxt = D_SREF;
				end
			end
			D_WR, D_RD: begin
				beat_nxt = beat_r + 2'h1;
				if (beat_r == LAST_BEAT) begin
					st_nxt = D_IDLE;
				end
			end
			D_RWAIT: begin
				st_nxt   = D_RD;
				beat_nxt = 2'h0;
			end
			D_SREF: begin
				if (lnk.cke) begin
					st_nxt = D_IDLE;
				end
			end
			default: st_nxt = D_IDLE;
		endcase
	end

	// commands outside the defined set, including a stray no-operation
	always_comb begin
		cmd_bad = 1'b0;
		if (lnk.cs_n) begin
			cmd_bad = 1'b0;
		end else if (lnk.cmd == CMD_NOP) begin
			cmd_bad = !(st_r == D_SREF || sr_exit_r);
		end else if (st_r != D_IDLE) begin
			cmd_bad = 1'b1;
		end else begin
			case (lnk.cmd)
				CMD_RD, CMD_WR, CMD_REF: cmd_bad = !lnk.cke;
				CMD_SRE:                 cmd_bad = lnk.cke;
				default:                 cmd_bad = 1'b1;
			endcase
		end
	end

	// state, index latch and status flags
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r      <= D_IDLE;
			beat_r    <= 2'h0;
			idx_r     <= '0;
			sr_exit_r <= RST_LOW;
			in_sref   <= RST_LOW;
			err_undef <= RST_LOW;
		end else begin
			st_r      <= st_nxt;
			beat_r    <= beat_nxt;
			sr_exit_r <= (st_r == D_SREF) && lnk.cke;
			in_sref   <= (st_nxt == D_SREF);
			if (st_r == D_IDLE && !lnk.cs_n) begin
				idx_r <= idx_cmd;
			end
			if (cmd_bad) begin
				err_undef <= 1'b1; // sticky until reset
			end
		end
	end

	// write clock: two bytes per clock, mask or inversion per the ball setting
	always_comb begin
		wfull    = wbuf_r;
		wfull_en = wen_r;
		for (int h = 0; h < 2; h++) begin
			wfull[(int'(beat_r) * 2 + h) * 8 +: 8] =
				lnk.dq[h * 8 +: 8] ^ {8{dbi_on & ~lnk.dm[h]}};
			wfull_en[int'(beat_r) * 2 + h] = (lnk.mr_dm != DMF_DM) | lnk.dm[h];
		end
	end

	// assemble the prefetch word over the burst
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wbuf_r <= '0;
			wen_r  <= '0;
		end else if (st_r == D_WR) begin
			wbuf_r <= wfull;
			wen_r  <= wfull_en;
		end
	end

	// one array access per burst, on its last clock
	always_ff @(posedge clk) begin
		if (st_r == D_WR && beat_r == LAST_BEAT) begin
			for (int k = 0; k < N_BYTES; k++) begin
				if (wfull_en[k]) begin
					mem[idx_r][k * 8 +: 8] <= wfull[k * 8 +: 8];
				end
			end
		end
	end

	// read clock: split the word into two coded bytes per clock
	always_comb begin
		dq_nxt = '0;
		dm_nxt = 2'h3;
		enc    = '0;
		for (int h = 0; h < 2; h++) begin
			enc = dbi_enc(rword[(int'(beat_nxt) * 2 + h) * 8 +: 8], dbi_on);
			dq_nxt[h * 8 +: 8] = enc[7:0];
			dm_nxt[h]          = enc[8];
		end
	end

	// pin drive and termination
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lnk.d_dq_o    <= '0;
			lnk.d_dq_oe_n <= RST_HIGH;
			lnk.d_dm_o    <= 2'h3;
			lnk.d_dm_oe_n <= RST_HIGH;
			lnk.d_term    <= RST_LOW;
		end else begin
			lnk.d_dq_o    <= dq_nxt;
			lnk.d_dq_oe_n <= (st_nxt != D_RD);
			lnk.d_dm_o    <= (st_nxt == D_RD) ? dm_nxt : TDQS_PAT;
			// ball drives inversion flags on reads, strobe on writes
			lnk.d_dm_oe_n <= !((st_nxt == D_RD && dbi_on) ||
				(st_nxt == D_WR && lnk.mr_dm == DMF_TDQS));
			// undriven lines terminate when requested and the setting allows, else float
			lnk.d_term    <= lnk.odt && lnk.mr_rtt_en && (st_nxt != D_RD);
		end
	end
endmodule // ddr_dev

// ===== rtl/ddr_host.sv
// memory controller end: request buffer, refresh pacing, burst data
`timescale 1ns/1ps
module req_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [PW-1:0]    wp_r;        // write pointer
	logic [PW-1:0]    rp_r;        // read pointer
	logic [PW:0]      cnt_r;       // fill level
	logic [PW:0]      cnt_nxt;     // next fill level
	logic             push;        // accepted write
	logic             pop;         // accepted read

	assign push     = in_valid & in_ready;
	assign pop      = out_valid & out_ready;
	assign cnt_nxt  = cnt_r + (PW + 1)'(push) - (PW + 1)'(pop);
	assign out_data = mem[rp_r];

	// pointers, level and registered full/empty
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_r      <= '0;
			rp_r      <= '0;
			cnt_r     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			wp_r      <= push ? wp_r + PW'(1) : wp_r;
			rp_r      <= pop ? rp_r + PW'(1) : rp_r;
			cnt_r     <= cnt_nxt;
			in_ready  <= (cnt_nxt != (PW + 1)'(DEPTH));
			out_valid <= (cnt_nxt != '0);
		end
	end

	// storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end
endmodule // req_fifo

module ddr_host import ddr_pkg::*; #(
	parameter int TOGGLE_LIMIT = TOG_LIMIT
) (
	input  wire logic               clk,
	input  wire logic               reset_n,
	input  wire logic               req_valid,
	output logic                    req_ready,
	input  wire logic               req_write,
	input  wire logic [1:0]         req_bg,
	input  wire logic [1:0]         req_ba,
	input  wire logic [COL_W-1:0]   req_col,
	input  wire logic [N_BYTES-1:0] req_mask,
	input  wire logic [WORD_W-1:0]  req_wdata,
	input  wire logic [1:0]         temp_band,
	input  wire logic               sr_req,
	input  wire dmf_e               dm_mode_sel,
	input  wire logic               rtt_en_sel,
	input  wire logic               dll_off_sel,
	output logic                    rd_valid,
	output logic [WORD_W-1:0]       rd_data,
	output logic                    in_sref,
	ddr_link.host                   lnk
);
	typedef enum logic [4:0] {
		H_IDLE  = 5'h01,
		H_WDAT  = 5'h02,
		H_RWAIT = 5'h04,
		H_RCAP  = 5'h08,
		H_SREF  = 5'h10
	} hst_e;

	hst_e               st_r;      // controller state
	logic [2:0]         beat_r;    // clock within a burst
	logic [1:0]         rl_r;      // read latency countdown
	logic [WORD_W-1:0]  wword_r;   // word being written
	logic [N_BYTES-1:0] wmask_r;   // its byte enables
	logic [REFI_W-1:0]  refi_r;    // refresh interval timer
	logic [REFI_W-1:0]  refi_lim;  // scaled interval
	logic               tick;      // one interval elapsed
	logic               ref_pend_r; // refresh owed
	logic [TOG_W-1:0]   tog_r;     // intervals since last toggle
	logic               tog_force; // toggle must happen now
	logic               ref_due;   // refresh issues next
	logic               cmd_go;    // a command leaves this clock
	logic               f_valid;   // buffered request present
	logic               f_pop;     // take buffered request
	logic [REQ_W-1:0]   f_data;    // buffered request
	logic [DQ_W-1:0]    wdq;       // write drive of this clock
	logic [1:0]         wdm;       // mask ball drive of this clock
	logic [8:0]         enc;       // coded byte scratch

	req_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (req_valid),
		.in_ready  (req_ready),
		.in_data   ({req_write, req_bg, req_ba, req_col, req_mask, req_wdata}),
		.out_valid (f_valid),
		.out_ready (f_pop),
		.out_data  (f_data)
	);

	// interval shortens twofold per temperature band
	assign refi_lim  = REFI_W'(TREFI_CYC) >> temp_band;
	assign tick      = (refi_r >= refi_lim - REFI_W'(1));
	assign tog_force = (tog_r >= TOG_W'(TOGGLE_LIMIT - 1));
	assign ref_due   = ref_pend_r | tog_force;
	assign cmd_go    = (st_r == H_IDLE) && (sr_req || ref_due || f_valid);
	assign f_pop     = (st_r == H_IDLE) && f_valid && !sr_req && !ref_due;

	// refresh timer, kept at zero while the device refreshes itself
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			refi_r <= '0;
		end else if (st_r == H_SREF || tick) begin
			refi_r <= '0;
		end else begin
			refi_r <= refi_r + REFI_W'(1);
		end
	end

	// owed refresh: a new interval wins over the clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ref_pend_r <= RST_LOW;
		end else if (st_r == H_SREF) begin
			ref_pend_r <= 1'b0;
		end else if (tick) begin
			ref_pend_r <= 1'b1;
		end else if (st_r == H_IDLE && !sr_req && ref_due) begin
			ref_pend_r <= 1'b0;
		end
	end

	// toggle watchdog: any select or clock-enable edge restarts it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tog_r <= '0;
		end else if (cmd_go || st_r == H_SREF) begin
			tog_r <= '0;
		end else if (tick) begin
			tog_r <= tog_r + TOG_W'(1);
		end
	end

	// settings follow the user only while the sequencer is idle, held through bursts and self refresh
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lnk.mr_dm      <= DMF_NF;
			lnk.mr_rtt_en  <= RST_LOW;
			lnk.mr_dll_off <= RST_LOW;
			lnk.mr_srt     <= RST_LOW;
		end else if (st_r == H_IDLE) begin
			lnk.mr_dm      <= dm_mode_sel;
			lnk.mr_rtt_en  <= rtt_en_sel;
			lnk.mr_dll_off <= dll_off_sel;
			lnk.mr_srt     <= (temp_band != 2'h0);
		end
	end

	// command sequencer; idle clocks deselect, never no-operation
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r       <= H_IDLE;
			beat_r     <= '0;
			rl_r       <= '0;
			wword_r    <= '0;
			wmask_r    <= '0;
			lnk.cke    <= RST_HIGH;
			lnk.cs_n   <= RST_HIGH;
			lnk.cmd    <= CMD_REF;
			lnk.bg     <= '0;
			lnk.ba     <= '0;
			lnk.col    <= '0;
			lnk.odt    <= RST_LOW;
			rd_valid   <= RST_LOW;
			in_sref    <= RST_LOW;
		end else begin
			lnk.cs_n <= 1'b1;
			rd_valid <= 1'b0;
			case (st_r)
				H_IDLE: begin
					if (sr_req) begin
						lnk.cs_n <= 1'b0;
						lnk.cmd  <= CMD_SRE;
						lnk.cke  <= 1'b0;
						in_sref  <= 1'b1;
						st_r     <= H_SREF;
					end else if (ref_due) begin
						lnk.cs_n <= 1'b0;
						lnk.cmd  <= CMD_REF;
					end else if (f_valid) begin
						lnk.cs_n <= 1'b0;
						lnk.cmd  <= f_data[REQ_W-1] ? CMD_WR : CMD_RD;
						lnk.bg   <= f_data[REQ_W-2 -: 2];
						lnk.ba   <= f_data[REQ_W-4 -: 2];
						lnk.col  <= f_data[REQ_W-6 -: COL_W];
						wmask_r  <= f_data[WORD_W +: N_BYTES];
						wword_r  <= f_data[WORD_W-1:0];
						beat_r   <= '0;
						lnk.odt  <= f_data[REQ_W-1];
						rl_r     <= dll_off_sel ? RL_DLL_OFF : RL_DLL_ON;
						st_r     <= f_data[REQ_W-1] ? H_WDAT : H_RWAIT;
					end
				end
				H_WDAT: begin
					beat_r <= beat_r + 3'h1;
					if (beat_r == WR_END) begin
						lnk.odt <= 1'b0;
						st_r    <= H_IDLE;
					end
				end
				H_RWAIT: begin
					rl_r   <= rl_r - 2'h1;
					beat_r <= '0;
					if (rl_r == RL_DLL_ON) begin
						st_r <= H_RCAP;
					end
				end
				H_RCAP: begin
					beat_r <= beat_r + 3'h1;
					if (beat_r[1:0] == LAST_BEAT) begin
						rd_valid <= 1'b1;
						st_r     <= H_IDLE;
					end
				end
				H_SREF: begin
					if (!sr_req) begin
						lnk.cke <= 1'b1; // exit with deselect
						in_sref <= 1'b0;
						st_r    <= H_IDLE;
					end
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end

	// write clock: two bytes with mask or inversion on the ball
	always_comb begin
		wdq = '0;
		wdm = 2'h3;
		enc = '0;
		for (int h = 0; h < 2; h++) begin
			enc = dbi_enc(wword_r[(int'(beat_r[1:0]) * 2 + h) * 8 +: 8],
				lnk.mr_dm == DMF_DBI);
			wdq[h * 8 +: 8] = enc[7:0];
			wdm[h] = (lnk.mr_dm == DMF_DM) ? wmask_r[int'(beat_r[1:0]) * 2 + h]
				: enc[8];
		end
	end

	// data pin drive during write bursts
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lnk.h_dq_o    <= '0;
			lnk.h_dq_oe_n <= RST_HIGH;
			lnk.h_dm_o    <= 2'h3;
			lnk.h_dm_oe_n <= RST_HIGH;
		end else if (st_r == H_WDAT && beat_r != WR_END) begin
			lnk.h_dq_o    <= wdq;
			lnk.h_dq_oe_n <= 1'b0;
			lnk.h_dm_o    <= wdm;
			lnk.h_dm_oe_n <= !(lnk.mr_dm == DMF_DM || lnk.mr_dm == DMF_DBI);
		end else begin
			lnk.h_dq_oe_n <= 1'b1;
			lnk.h_dm_oe_n <= 1'b1;
		end
	end

	// read capture, undoing inversion per byte
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= '0;
		end else if (st_r == H_RCAP) begin
			for (int h = 0; h < 2; h++) begin
				rd_data[(int'(beat_r[1:0]) * 2 + h) * 8 +: 8] <= lnk.dq[h * 8 +: 8] ^
					{8{(lnk.mr_dm == DMF_DBI) & ~lnk.dm[h]}};
			end
		end
	end
endmodule // ddr_host

// ===== rtl/ddr_link.sv
// link between memory controller and memory device
`timescale 1ns/1ps
interface ddr_link;
	import ddr_pkg::*;
	logic             cke;        // clock enable
	logic             cs_n;       // chip select, low active
	cmd_e             cmd;        // command code
	logic [1:0]       bg;         // bank group
	logic [1:0]       ba;         // bank
	logic [COL_W-1:0] col;        // word slot
	logic             odt;        // termination request
	dmf_e             mr_dm;      // mask ball function setting
	logic             mr_rtt_en;  // termination enabled setting
	logic             mr_dll_off; // dll disabled setting
	logic             mr_srt;     // high-temperature self refresh setting
	logic [DQ_W-1:0]  h_dq_o;     // controller data drive
	logic             h_dq_oe_n;  // controller data enable, low active
	logic [1:0]       h_dm_o;     // controller mask ball drive
	logic             h_dm_oe_n;  // controller mask enable, low active
	logic [DQ_W-1:0]  d_dq_o;     // device data drive
	logic             d_dq_oe_n;  // device data enable, low active
	logic [1:0]       d_dm_o;     // device mask ball drive
	logic             d_dm_oe_n;  // device mask enable, low active
	logic             d_term;     // device terminates undriven lines
	logic [DQ_W-1:0]  dq;         // resolved data wires {fall, rise}
	logic [1:0]       dm;         // resolved mask ball {fall, rise}

	// wire resolution: a driver wins, else termination pulls high, else floating lines read low
	assign dq = !h_dq_oe_n ? h_dq_o : !d_dq_oe_n ? d_dq_o : d_term ? '1 : '0;
	assign dm = !h_dm_oe_n ? h_dm_o : !d_dm_oe_n ? d_dm_o : d_term ? '1 : '0;

	modport host (output cke, cs_n, cmd, bg, ba, col, odt, mr_dm, mr_rtt_en,
		mr_dll_off, mr_srt, h_dq_o, h_dq_oe_n, h_dm_o, h_dm_oe_n, input dq, dm);
	modport dev (input cke, cs_n, cmd, bg, ba, col, odt, mr_dm, mr_rtt_en,
		mr_dll_off, mr_srt, dq, dm, output d_dq_o, d_dq_oe_n, d_dm_o, d_dm_oe_n,
		d_term);
endinterface

// ===== rtl/ddr_pkg.sv
// shared constants, types and helpers for both ends of the memory link
package ddr_pkg;
	localparam int CLK_MHZ    = 100;                // command clock rate
	localparam int TREFI_NS   = 7800;               // base average refresh interval
	localparam int TREFI_CYC  = TREFI_NS * CLK_MHZ / 1000; // longest time: rounds down
	localparam int REFI_W     = 10;                 // refresh timer width
	localparam int TOG_W      = 14;                 // toggle watchdog width
	localparam int TOG_LIMIT  = 8192;               // refresh intervals between toggles
	localparam int N_W        = 8;                  // pin data width n
	localparam int DQ_W       = 2 * N_W;            // both halves of one clock
	localparam int WORD_W     = 8 * N_W;            // one prefetch word
	localparam int N_BYTES    = WORD_W / 8;         // byte lanes of a word
	localparam int BANK_W     = 4;                  // bank index width
	localparam int COL_W      = 2;                  // word slot within a bank
	localparam int IDX_W      = BANK_W + COL_W;     // array index width
	localparam int MEM_DEPTH  = 64;                 // words held by the array
	localparam int FIFO_DEPTH = 8;                  // request buffer depth
	localparam int REQ_W      = 5 + COL_W + N_BYTES + WORD_W; // packed request
	localparam logic [1:0] LAST_BEAT  = 2'h3;       // fourth clock of a burst
	localparam logic [2:0] WR_END     = 3'h4;       // host write burst release
	localparam logic [1:0] RL_DLL_ON  = 2'h1;       // read latency, dll on
	localparam logic [1:0] RL_DLL_OFF = 2'h2;       // read latency, dll off
	localparam logic [1:0] TDQS_PAT   = 2'h1;       // strobe pattern per clock
	localparam logic       RST_HIGH   = 1'b1;       // idle level of low-active pins
	localparam logic       RST_LOW    = 1'b0;       // idle level of flags

	// command codes, valid while the select is low
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_RD  = 3'h1,
		CMD_WR  = 3'h2,
		CMD_REF = 3'h3,
		CMD_SRE = 3'h4
	} cmd_e;

	// function of the shared mask ball
	typedef enum logic [1:0] {
		DMF_NF   = 2'h0,
		DMF_DM   = 2'h1,
		DMF_DBI  = 2'h2,
		DMF_TDQS = 2'h3
	} dmf_e;

	// bank index: wide config has two groups, narrow config four
	function automatic logic [BANK_W-1:0] bank_idx(input logic [1:0] bg,
			input logic [1:0] ba, input logic x16);
		return x16 ? {1'b0, bg[0], ba} : {bg, ba};
	endfunction

	// inversion coding of a byte: returns {inv_n, byte}
	function automatic logic [8:0] dbi_enc(input logic [7:0] b, input logic en);
		int ones;
		ones = 0;
		for (int i = 0; i < 8; i++) ones += int'(b[i]);
		return (en && ones > 4) ? {1'b0, ~b} : {1'b1, b};
	endfunction
endpackage

// ===== testbench/ddr_link_chk.sv
// link checker: command, burst and pin rules
`timescale 1ns/1ps
module ddr_link_chk import ddr_pkg::*; (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       cs_n,
	input wire cmd_e       cmd,
	input wire dmf_e       mr_dm,
	input wire logic       mr_dll_off,
	input wire logic       h_dq_oe_n,
	input wire logic       d_dq_oe_n,
	input wire logic       h_dm_oe_n,
	input wire logic       d_dm_oe_n,
	input wire logic       odt,
	input wire logic       mr_rtt_en,
	input wire logic       d_term,
	input wire logic [1:0] d_dm_o
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// write: four host data clocks, then release
	a_wr_burst: assert property (!cs_n && cmd == CMD_WR |=> !h_dq_oe_n [*4] ##1 h_dq_oe_n)
		else $error("write burst shape wrong");
	// read with dll on: four device data clocks at once
	a_rd_burst: assert property (!cs_n && cmd == CMD_RD && !mr_dll_off |=> !d_dq_oe_n [*4])
		else $error("read burst shape wrong");
	// read with dll off: one clock later
	a_rd_slow: assert property (!cs_n && cmd == CMD_RD && mr_dll_off |=> d_dq_oe_n ##1 !d_dq_oe_n [*4])
		else $error("slow read latency wrong");
	// idle slots deselect instead
	a_no_nop: assert property (!cs_n |-> cmd != CMD_NOP)
		else $error("no-operation issued");
	// only known codes reach the wire
	a_cmd_known: assert property (!cs_n |-> cmd inside {CMD_RD, CMD_WR, CMD_REF, CMD_SRE})
		else $error("undefined command issued");
	// one driver at a time, the rest terminate or float
	a_bus_one: assert property (!(!h_dq_oe_n && !d_dq_oe_n))
		else $error("data wires driven from both ends");
	// strobe mode: device drives the pattern during write data
	a_tdqs_out: assert property (mr_dm == DMF_TDQS && !h_dq_oe_n |-> !d_dm_oe_n && d_dm_o == TDQS_PAT)
		else $error("strobe pattern missing");
	// no-function mode: mask ball left alone
	a_nf_quiet: assert property (mr_dm == DMF_NF |-> h_dm_oe_n && d_dm_oe_n)
		else $error("mask ball driven in no-function mode");
	// termination follows request and setting, never while the device drives
	a_term_sel: assert property (d_term == ($past(odt & mr_rtt_en) && d_dq_oe_n))
		else $error("termination state wrong");
endmodule // ddr_link_chk

// ===== testbench/test_ddr_general_operating_rules.sv
// bench: host and device joined over the link
`timescale 1ns/1ps
module test_ddr_general_operating_rules import ddr_pkg::*;;
	logic        clk = 0, reset_n = 0, cfg_x16 = 0, req_valid = 0, req_write = 0, sr_req = 0;
	logic        rtt_en_sel = 0, dll_off_sel = 0, req_ready, rd_valid, h_sref, d_sref;
	logic        x16_mode, err_undef;
	logic [1:0]  req_bg = 0, req_ba = 0, req_col = 0, temp_band = 0;
	logic [7:0]  req_mask = 0;
	logic [63:0] req_wdata = 0, rd_data;
	logic [63:0] mem [64];      // expected array contents
	dmf_e        dm_mode_sel = DMF_NF;
	int          errors = 0, n_tests = 0, g;
	always #5 clk = ~clk;
	ddr_link ddr_link_i ();
	ddr_host #(.TOGGLE_LIMIT(4)) ddr_host_i (.clk(clk), .reset_n(reset_n),
		.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_bg(req_bg),
		.req_ba(req_ba), .req_col(req_col), .req_mask(req_mask), .req_wdata(req_wdata),
		.temp_band(temp_band), .sr_req(sr_req), .dm_mode_sel(dm_mode_sel),
		.rtt_en_sel(rtt_en_sel), .dll_off_sel(dll_off_sel), .rd_valid(rd_valid),
		.rd_data(rd_data), .in_sref(h_sref), .lnk(ddr_link_i.host));
	ddr_dev ddr_dev_i (.clk(clk), .reset_n(reset_n), .cfg_x16(cfg_x16), .lnk(ddr_link_i.dev),
		.in_sref(d_sref), .x16_mode(x16_mode), .err_undef(err_undef));
	ddr_link_chk ddr_link_chk_i (.clk(clk), .reset_n(reset_n), .cs_n(ddr_link_i.cs_n),
		.cmd(ddr_link_i.cmd), .mr_dm(ddr_link_i.mr_dm), .mr_dll_off(ddr_link_i.mr_dll_off),
		.h_dq_oe_n(ddr_link_i.h_dq_oe_n), .d_dq_oe_n(ddr_link_i.d_dq_oe_n),
		.h_dm_oe_n(ddr_link_i.h_dm_oe_n), .d_dm_oe_n(ddr_link_i.d_dm_oe_n),
		.odt(ddr_link_i.odt), .mr_rtt_en(ddr_link_i.mr_rtt_en), .d_term(ddr_link_i.d_term),
		.d_dm_o(ddr_link_i.d_dm_o));
	// array slot of an address: wide config ignores the upper group bit
	function automatic logic [5:0] idx(input logic [5:0] a);
		return cfg_x16 ? {1'b0, a[4:0]} : a;
	endfunction
	// word after a write: only mask mode keeps disabled bytes
	function automatic logic [63:0] merged(input logic [63:0] o, n, input logic [7:0] m);
		for (int k = 0; k < 8; k++) if (dm_mode_sel != DMF_DM || m[k]) o[8*k+:8] = n[8*k+:8];
		return o;
	endfunction
	// sampled refresh command on the wire
	function automatic logic isref();
		return ddr_link_i.cs_n === 1'b0 && ddr_link_i.cmd === CMD_REF;
	endfunction
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// present one request, hold it until taken; valid stays up
	task automatic push(input logic w, input logic [5:0] a, input logic [7:0] m,
			input logic [63:0] d);
		req_valid <= 1'b1;
		req_write <= w;
		{req_bg, req_ba, req_col} <= a;
		req_mask <= m;
		req_wdata <= d;
		do @(posedge clk); while (req_ready !== 1'b1);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] m, input logic [63:0] d);
		push(1'b1, a, m, d);
		mem[idx(a)] = merged(mem[idx(a)], d, m);
	endtask
	// read, wait for the answer under a bound, compare
	task automatic rd(input logic [5:0] a);
		push(1'b0, a, 8'h00, 64'h0);
		req_valid <= 1'b0;
		for (int i = 0; i < 300 && rd_valid !== 1'b1; i++) @(posedge clk);
		chk("rd_valid", 1'b1, rd_valid);
		chk("rd_data", mem[idx(a)], rd_data);
	endtask
	// gap in cycles between two refresh commands
	task automatic refgap(output int n);
		for (int i = 0; i < 2000 && !isref(); i++) @(posedge clk);
		@(posedge clk);
		for (n = 1; n < 2000 && !isref(); n++) @(posedge clk);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// watchdog well beyond the expected run
	initial begin
		#500000;
		errors++;
		report_and_stop();
	end
	// main sequence: two straps, fill, all modes, refresh pacing
	initial begin
		void'($urandom(32'h16c1));
		for (int x = 0; x < 2; x++) begin
			cfg_x16 <= x[0];
			reset_n <= 1'b0;
			repeat (12) @(posedge clk);
			reset_n <= 1'b1;
			repeat (2) @(posedge clk);
			chk("x16_mode", x, x16_mode);
			sr_req <= 1'b1;
			for (int i = 0; i < 50 && h_sref !== 1'b1; i++) @(posedge clk);
			@(posedge clk); // device enters one clock after the host
			chk("in_sref", 2'h3, {h_sref, d_sref});
			// self refresh stalls the buffer: eight fit, the ninth is refused
			for (int a = 0; a < 64; a++) begin
				if (a == 8) begin
					@(posedge clk);
					chk("req_ready", 1'b0, req_ready);
					sr_req <= 1'b0;
				end
				wr(a[5:0], 8'hff, {$urandom, $urandom});
			end
			rd(6'h3f);
			$display("test fill done");
			// every ball function with dll on and off, back-to-back writes
			for (int m = 0; m < 8; m++) begin
				dm_mode_sel <= dmf_e'(m[1:0]);
				dll_off_sel <= m[2];
				rtt_en_sel <= 1'($urandom);
				repeat (2) @(posedge clk);
				repeat (5) begin
					wr(6'($urandom), 8'($urandom), {$urandom, $urandom});
					wr(6'($urandom), 8'($urandom), {$urandom, $urandom});
					rd(6'($urandom));
				end
			end
			$display("test modes done");
			if (x == 0) for (int b = 0; b < 4; b++) begin
				temp_band <= b[1:0];
				refgap(g);
				refgap(g);
				chk("ref_gap", TREFI_CYC >> b, g);
				chk("mr_srt", b != 0, ddr_link_i.mr_srt);
			end
			chk("err_undef", 1'b0, err_undef);
			$display("test pass done");
		end
		report_and_stop();
	end
endmodule // test_ddr_general_operating_rules
